// >>> core/acr_top.sv
// Converter control, status and result registers
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps

// Contract
// [RQ1] The completion flag in bit 7 of the control/status register is set when a conversion ends and stays set until cleared.
// [RQ2] Reading the high result register or writing the control/status register clears the completion flag.
// [RQ3] Slow and speed 0,0 give clock divided by 2, 0,1 the undivided clock, 1,0 clock divided by 4; at the 100 MHz clock here 0,1 gives clock divided by 2.
// [RQ4] The undivided clock may only be used at 4 MHz or below, and software must not pick it above that.
// [RQ5] Slow and speed both set give clock divided by 2, as both cleared do.
// [RQ6] Clearing the on bit disables the converter and stops conversion; setting it enables and starts it.
// [RQ7] The four low control bits pick the analog input as a binary index from 0 to 15.
// [RQ8] The high result register returns result bits 9 to 2 in its bits 7 to 0.
// [RQ9] The low result register returns result bits 1 and 0 in bits 1:0 and reads zero above.
// [RQ10] Every control/status bit is read-write except the completion flag, which any write clears whatever value is written.
// [RQ11] Both result registers are loaded with the whole result in the cycle the completion flag is set.
module acr_top
	import acr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [2:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	// Analog converter side
	output logic             converter_on,
	output logic      [3:0]  input_select,
	output logic             conv_clk_en,
	output logic             sample_start,
	input  wire logic [9:0]  conv_data,
	// Interrupt
	output logic             irq
);

	// ********************************************************************
	// State
	// ********************************************************************
	typedef struct packed {
		acr_state_t  fsm;
		logic        done;
		logic        speed;
		logic        on;
		logic        slow;
		logic [3:0]  sel;
		logic [9:0]  result;
		logic [7:0]  count;
		logic [7:0]  conv_time;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		logic [7:0]  rdata;
		logic        start;
	} acr_state_s_t;

	acr_state_s_t s_reg;
	acr_state_s_t s_next;
	acr_div_t     div_sel;
	logic         tick;
	logic         finish;
	logic         csr_wr;
	logic         high_rd;

	// ********************************************************************
	// Decoding
	// ********************************************************************
	function automatic acr_div_t pick_div(input logic slow, input logic speed);
		case ({slow, speed})
			2'b01:   pick_div = UNDIV_ALLOWED ? ACR_DIV1 : ACR_DIV2; // [RQ3] [RQ4]
			2'b10:   pick_div = ACR_DIV4; // [RQ3]
			default: pick_div = ACR_DIV2; // [RQ3] [RQ5]
		endcase
	endfunction : pick_div

	function automatic logic hit(input logic [2:0] addr, input logic [2:0] target);
		hit = (addr == target);
	endfunction : hit

	// Undivided rate is held back above 4 MHz since the analog side cannot follow
	assign div_sel = pick_div(s_reg.slow, s_reg.speed);

	acr_divider u_div (
		.clk     (clk),
		.rst     (rst),
		.run     (s_reg.on),
		.div_sel (div_sel),
		.tick    (tick)
	);

	assign csr_wr  = reg_write && hit(reg_addr, ADDR_CONTROL_STATUS);
	assign high_rd = reg_read && hit(reg_addr, ADDR_RESULT_HIGH);
	assign finish  = (s_reg.fsm == ACR_SAMPLE) && tick && (s_reg.count >= s_reg.conv_time);

	// ********************************************************************
	// Next state
	// ********************************************************************
	always_comb begin
		s_next       = s_reg;
		s_next.start = 1'b0;

		// Conversion sequencer, paced by the converter clock enable
		case (s_reg.fsm)
			ACR_IDLE: begin
				if (s_reg.on) begin
					s_next.fsm   = ACR_SAMPLE; // [RQ6]
					s_next.count = 8'h00;
					s_next.start = 1'b1;
				end
			end
			ACR_SAMPLE: begin
				if (tick) begin
					s_next.count = s_reg.count + 8'h01;
				end
				if (finish) begin
					s_next.fsm = ACR_DONE;
				end
			end
			ACR_DONE: begin
				// Continuous mode: next conversion starts straight away
				s_next.fsm   = ACR_SAMPLE;
				s_next.count = 8'h00;
				s_next.start = 1'b1;
			end
			default: begin
				s_next.fsm = ACR_IDLE;
			end
		endcase

		// Clears first so that a finishing conversion wins
		if (csr_wr || high_rd) begin
			s_next.done = 1'b0; // [RQ2]
		end
		if (csr_wr) begin
			s_next.speed = reg_wdata[CSR_SPEED_BIT]; // [RQ10]
			s_next.on    = reg_wdata[CSR_ON_BIT];
			s_next.slow  = reg_wdata[CSR_SLOW_BIT];
			s_next.sel   = reg_wdata[CSR_SEL_MSB:0]; // [RQ7]
		end
		if (reg_write && hit(reg_addr, ADDR_IRQ_STATUS)) begin
			s_next.irq_status = s_reg.irq_status & ~reg_wdata[1:0];
		end
		if (reg_write && hit(reg_addr, ADDR_IRQ_MASK)) begin
			s_next.irq_mask = reg_wdata[1:0];
		end
		if (reg_write && hit(reg_addr, ADDR_CONV_TIME)) begin
			s_next.conv_time = reg_wdata;
		end

		if (finish) begin
			s_next.done          = 1'b1; // [RQ1]
			s_next.result        = conv_data; // [RQ11]
			s_next.irq_status[0] = 1'b1;
		end

		// Turning off aborts the conversion in flight
		if (!s_next.on) begin
			s_next.fsm = ACR_IDLE; // [RQ6]
			if (s_reg.fsm != ACR_IDLE) begin
				s_next.irq_status[1] = 1'b1;
			end
		end

		// Read data stand for exactly the cycle after the strobe
		s_next.rdata = 8'h00;
		if (reg_read) begin
			case (reg_addr)
				ADDR_CONTROL_STATUS: s_next.rdata = {s_reg.done, s_reg.speed, s_reg.on, s_reg.slow, s_reg.sel};
				ADDR_RESULT_HIGH:    s_next.rdata = s_reg.result[9:2]; // [RQ8]
				ADDR_RESULT_LOW:     s_next.rdata = {6'h00, s_reg.result[1:0]}; // [RQ9]
				ADDR_IRQ_STATUS:     s_next.rdata = {6'h00, s_reg.irq_status};
				ADDR_IRQ_MASK:       s_next.rdata = {6'h00, s_reg.irq_mask};
				ADDR_CONV_TIME:      s_next.rdata = s_reg.conv_time;
				default:             s_next.rdata = 8'h00;
			endcase
		end
	end

	// ********************************************************************
	// Registers
	// ********************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg            <= '0;
			s_reg.fsm        <= ACR_IDLE;
			s_reg.conv_time  <= CONV_TIME_RESET;
			s_reg.irq_mask   <= IRQ_MASK_RESET[1:0];
			s_reg.result     <= {RESULT_RESET, 2'b00};
		end else begin
			s_reg <= s_next;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign reg_rdata    = s_reg.rdata;
	assign converter_on = s_reg.on; // [RQ6]
	assign input_select = s_reg.sel; // [RQ7]
	assign conv_clk_en  = tick;
	assign sample_start = s_reg.start;
	assign irq          = |(s_reg.irq_status & s_reg.irq_mask);

endmodule : acr_top

// >>> core/acr_pkg.sv
// Package for the converter control and result register block
package acr_pkg;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam logic [2:0] ADDR_CONTROL_STATUS = 3'h0;
	localparam logic [2:0] ADDR_RESULT_HIGH    = 3'h1;
	localparam logic [2:0] ADDR_RESULT_LOW     = 3'h2;
	localparam logic [2:0] ADDR_IRQ_STATUS     = 3'h3;
	localparam logic [2:0] ADDR_IRQ_MASK       = 3'h4;
	localparam logic [2:0] ADDR_CONV_TIME      = 3'h5;

	// ********************************************************************
	// Fields
	// ********************************************************************
	localparam int CSR_DONE_BIT    = 7;
	localparam int CSR_SPEED_BIT   = 6;
	localparam int CSR_ON_BIT      = 5;
	localparam int CSR_SLOW_BIT    = 4;
	localparam int CSR_SEL_MSB     = 3;
	localparam int RESULT_WIDTH    = 10;
	localparam int REG_WIDTH       = 8;
	localparam int INPUT_COUNT     = 16;

	// ********************************************************************
	// Reset values and timing
	// ********************************************************************
	localparam logic [7:0] CSR_RESET       = 8'h00;
	localparam logic [7:0] RESULT_RESET    = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET  = 8'h00;
	localparam logic [7:0] CONV_TIME_RESET = 8'h0E;
	localparam real        CLK_FREQ_MHZ    = 100.0;
	localparam real        UNDIV_MAX_MHZ   = 4.0;
	localparam logic       UNDIV_ALLOWED   = (CLK_FREQ_MHZ <= UNDIV_MAX_MHZ);

	// ********************************************************************
	// Types
	// ********************************************************************
	typedef enum logic [1:0] {
		ACR_IDLE   = 2'b00,
		ACR_SAMPLE = 2'b01,
		ACR_DONE   = 2'b11
	} acr_state_t;

	typedef enum logic [1:0] {
		ACR_DIV2 = 2'b00,
		ACR_DIV1 = 2'b01,
		ACR_DIV4 = 2'b10
	} acr_div_t;

endpackage : acr_pkg

// >>> core/acr_divider.sv
// Converter clock enable divider
`timescale 1ns/1ps
module acr_divider
	import acr_pkg::*;
(
	// Clock and reset
	input  wire logic     clk,
	input  wire logic     rst,
	// Control
	input  wire logic     run,
	input  wire acr_div_t div_sel,
	// Enable out
	output logic          tick
);

	// ********************************************************************
	// Divider state
	// ********************************************************************
	typedef struct packed {
		logic [1:0] count;
	} acr_div_state_t;

	acr_div_state_t state_reg;
	acr_div_state_t state_next;
	logic [1:0]     limit;

	always_comb begin
		state_next = state_reg;
		case (div_sel)
			ACR_DIV1: limit = 2'h0;
			ACR_DIV4: limit = 2'h3;
			default:  limit = 2'h1;
		endcase
		tick = run && (state_reg.count >= limit);
		if (!run || tick) begin
			state_next.count = 2'h0;
		end else begin
			state_next.count = state_reg.count + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : acr_divider

// >>> tb/acr_monitor.sv
// Port checks for the converter register block
`timescale 1ns/1ps
module acr_monitor
	import acr_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	// Converter side
	input wire logic       converter_on,
	input wire logic [3:0] input_select,
	input wire logic       conv_clk_en,
	input wire logic       sample_start,
	input wire logic       irq
);
	// ****************
	// Checks
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire csr_wr = reg_write && reg_addr == ADDR_CONTROL_STATUS;
	chk_low_zero: assert property (
		$past(reg_read) && $past(reg_addr) == ADDR_RESULT_LOW |-> reg_rdata[7:2] == 6'h00) else $error("low pad set");
	chk_on_follow: assert property (
		csr_wr |=> converter_on == $past(reg_wdata[CSR_ON_BIT])) else $error("on bit lost");
	chk_sel_follow: assert property (
		csr_wr |=> input_select == $past(reg_wdata[3:0])) else $error("select lost");
	chk_off_quiet: assert property (
		!converter_on |-> !conv_clk_en) else $error("tick while off");
	chk_tick_gap: assert property (
		conv_clk_en |=> !conv_clk_en) else $error("ticks too close");
	chk_start_once: assert property (
		$rose(converter_on) |-> ##1 sample_start ##1 !sample_start) else $error("start pulse bad");
	chk_csr_back: assert property (
		csr_wr ##2 reg_read && reg_addr == ADDR_CONTROL_STATUS |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 3))
		else $error("control readback bad");
	chk_done_clear: assert property (
		reg_read && reg_addr == ADDR_RESULT_HIGH && !converter_on ##2 reg_read && reg_addr == ADDR_CONTROL_STATUS
		|=> !reg_rdata[CSR_DONE_BIT]) else $error("done not cleared");
	cover property ($rose(irq));
	cover property (sample_start);
	cover property (csr_wr && reg_wdata[CSR_ON_BIT]);
endmodule : acr_monitor

// >>> tb/acr_top_tb.sv
// Self-checking bench for the converter register block
`timescale 1ns/1ps
module acr_top_tb
	import acr_pkg::*;
;
	logic       clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
	logic       converter_on, conv_clk_en, sample_start, irq;
	logic [3:0] input_select;
	logic [9:0] conv_data = 10'h2B5;
	int         fail_count = 0, checks_done = 0, n, e;
	always #5 clk = ~clk;
	acr_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .converter_on(converter_on), .input_select(input_select),
		.conv_clk_en(conv_clk_en), .sample_start(sample_start), .conv_data(conv_data), .irq(irq));
	// ****************
	// Bus tasks
	// ****************
	task automatic check(logic [9:0] seen, logic [9:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(logic [2:0] a, logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rdc(logic [2:0] a, logic [7:0] x);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 check(reg_rdata, x);
	endtask : rdc
	task automatic wait_irq();
		n = 0;
		while (irq !== 1'b1 && n < 300) begin
			@(posedge clk) #1;
			n++;
		end
	endtask : wait_irq
	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		rdc(ADDR_CONTROL_STATUS, 8'h00);
		rdc(ADDR_RESULT_HIGH, 8'h00);
		rdc(ADDR_RESULT_LOW, 8'h00);
		rdc(ADDR_IRQ_STATUS, 8'h00);
		rdc(ADDR_CONV_TIME, CONV_TIME_RESET);
		rdc(3'h6, 8'h00);
		wr(ADDR_CONTROL_STATUS, 8'hDA);
		rdc(ADDR_CONTROL_STATUS, 8'h5A);
		check(input_select, 4'hA);
	endtask : t_reset
	task automatic t_div();
		// Undivided falls back to half rate at this clock
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CONTROL_STATUS, {1'b0, i[0], 1'b1, i[1], 4'h3});
			n = 0;
			do @(posedge clk) #1; while (!conv_clk_en && ++n < 50);
			n = 0;
			do begin @(posedge clk) #1; n++; end while (!conv_clk_en && n < 50);
			e = (i == 2) ? 4 : (i == 1 && UNDIV_ALLOWED) ? 1 : 2;
			check(n[9:0], e[9:0]);
		end
	endtask : t_div
	task automatic t_conv();
		wr(ADDR_CONTROL_STATUS, 8'h00);
		// Events left from the clock sweep would fake an early finish
		wr(ADDR_IRQ_STATUS, 8'h03);
		wr(ADDR_IRQ_MASK, 8'h01);
		wr(ADDR_CONTROL_STATUS, 8'h2F);
		#1 check(converter_on, 1'b1);
		check(input_select, 4'hF);
		wait_irq();
		rdc(ADDR_CONTROL_STATUS, 8'hAF);
		rdc(ADDR_RESULT_HIGH, 8'hAD);
		rdc(ADDR_RESULT_LOW, 8'h01);
		rdc(ADDR_CONTROL_STATUS, 8'h2F);
		wr(ADDR_IRQ_MASK, 8'h00);
		@(posedge clk) #1 check(irq, 1'b0);
		wr(ADDR_IRQ_MASK, 8'h01);
		@(posedge clk) #1 check(irq, 1'b1);
		wr(ADDR_IRQ_STATUS, 8'h01);
		@(posedge clk) #1 check(irq, 1'b0);
	endtask : t_conv
	task automatic t_abort();
		// Next finish of the running conversion, then a write must clear it
		wait_irq();
		rdc(ADDR_CONTROL_STATUS, 8'hAF);
		wr(ADDR_CONTROL_STATUS, 8'h2F);
		rdc(ADDR_CONTROL_STATUS, 8'h2F);
		wr(ADDR_IRQ_MASK, 8'h02);
		wr(ADDR_CONTROL_STATUS, 8'h00);
		@(posedge clk) #1 check(irq, 1'b1);
		check(conv_clk_en, 1'b0);
		check(input_select, 4'h0);
		rdc(ADDR_RESULT_HIGH, 8'hAD);
		rdc(ADDR_CONTROL_STATUS, 8'h00);
		wr(ADDR_IRQ_STATUS, 8'h03);
		@(posedge clk) #1 check(irq, 1'b0);
	endtask : t_abort
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_div();
		t_conv();
		t_abort();
		report_and_stop();
	end
	// Bound well above the whole sequence
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
endmodule : acr_top_tb
bind acr_top acr_monitor u_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .converter_on(converter_on),
	.input_select(input_select), .conv_clk_en(conv_clk_en), .sample_start(sample_start), .irq(irq));
